//--- ssrwd_core.sv
// Write decode, byte masks and data pin enable of the synchronous memory front end.
module ssrwd_core (
	input  wire logic                          clock_i,                // Clock.
	input  wire logic                          rst_i,                  // Synchronous reset, high.
	input  wire logic                          clk_en_i,               // Clock enable, high.
	input  wire logic                          chip_select_i,          // Device selected, high.
	input  wire logic                          proc_addr_strobe_n_i,   // Processor strobe, low.
	input  wire logic                          ctrl_addr_strobe_n_i,   // Controller strobe, low.
	input  wire logic                          global_write_n_i,       // Global write, low.
	input  wire logic                          byte_write_enable_n_i,  // Byte write enable, low.
	input  wire logic                          lane0_write_n_i,        // Lane 0 strobe, low.
	input  wire logic                          lane1_write_n_i,        // Lane 1 strobe, low.
	input  wire logic                          lane2_write_n_i,        // Lane 2 strobe, low.
	input  wire logic                          lane3_write_n_i,        // Lane 3 strobe, low.
	input  wire logic                          output_enable_n_i,      // Output enable, low, async.
	input  wire logic [ssrwd_pkg::DATA_W-1:0]  dq_i,                   // Data pins, input side.
	output logic      [ssrwd_pkg::DATA_W-1:0]  dq_o,                   // Data pins, output side.
	output logic      [ssrwd_pkg::DATA_W-1:0]  dq_oe_o,                // Data pin enables, high drives.
	input  wire logic [ssrwd_pkg::DATA_W-1:0]  rd_data_i,              // Word read from the array.
	output logic                               write_o,                // Current cycle is a write.
	output logic      [ssrwd_pkg::LANES-1:0]   byte_we_o,              // Lanes written this cycle.
	output logic      [ssrwd_pkg::DATA_W-1:0]  wr_data_o               // Write data for the array.
);

	ssrwd_pkg::ssrwd_state_s st_r;   // Registered state.
	ssrwd_pkg::ssrwd_state_s st_nxt; // Next state.

	logic [ssrwd_pkg::LANES-1:0] lanes_n; // Lane strobes gathered, low active.
	logic                        strobe;  // Either address strobe active.
	logic                        take;    // A cycle is taken at this edge.
	logic                        pstart;  // Processor strobe starts the cycle.

	// Lanes that the global write, or byte write enable with their strobe, asks to update.
	function automatic logic [ssrwd_pkg::LANES-1:0] lane_mask(
		input logic                        gw_n,
		input logic                        bwe_n,
		input logic [ssrwd_pkg::LANES-1:0] ln_n
	);
		logic [ssrwd_pkg::LANES-1:0] m;
		m = ssrwd_pkg::MASK_NONE;
		if (!gw_n) begin
			m = ssrwd_pkg::MASK_ALL; // R1
		end else if (!bwe_n) begin
			m = ~ln_n; // R3
		end
		return m;
	endfunction

	assign lanes_n = {lane3_write_n_i, lane2_write_n_i, lane1_write_n_i, lane0_write_n_i};
	assign strobe  = !proc_addr_strobe_n_i || !ctrl_addr_strobe_n_i;
	// A strobe opens a cycle while selected; without one a running cycle continues.
	assign take    = strobe ? chip_select_i : (st_r.cyc != ssrwd_pkg::SSRWD_IDLE);
	assign pstart  = !proc_addr_strobe_n_i && chip_select_i;

	// Next state: decode the write controls, which the processor strobe overrides.
	always_comb begin
		logic [ssrwd_pkg::LANES-1:0] m;
		m      = ssrwd_pkg::MASK_NONE;
		st_nxt = st_r;
		if (!take) begin
			// A strobe while deselected, or nothing running, leaves the bus idle.
			st_nxt.cyc  = ssrwd_pkg::SSRWD_IDLE;
			st_nxt.mask = ssrwd_pkg::MASK_NONE;
		end else begin
			// The processor strobe forces a read, whatever the write pins say.
			m = pstart ? ssrwd_pkg::MASK_NONE
				: lane_mask(global_write_n_i, byte_write_enable_n_i, lanes_n); // R4 R5
			st_nxt.mask = m;
			// Any lane written makes it a write, none makes it a read.
			st_nxt.cyc  = (m != ssrwd_pkg::MASK_NONE) ? ssrwd_pkg::SSRWD_WRITE
				: ssrwd_pkg::SSRWD_READ; // R1 R2
			if (m != ssrwd_pkg::MASK_NONE) begin
				st_nxt.wdat = dq_i;
			end
		end
		// Read data is refreshed every enabled edge; the pins only show it in a read.
		st_nxt.rdat = rd_data_i;
	end

	// State register; the clock enable freezes everything except reset, which loads the reset state even with the enable low.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_r <= ssrwd_pkg::STATE_RST;
		end else if (clk_en_i) begin
			st_r <= st_nxt;
		end
	end

	// Pin drive is decided without the clock, so output enable acts at once.
	// Write cycles mask output enable so the bus is never fought over.
	always_comb begin
		if (st_r.cyc == ssrwd_pkg::SSRWD_READ && !output_enable_n_i) begin
			dq_oe_o = ssrwd_pkg::OE_ALL; // R7 R10
		end else begin
			dq_oe_o = ssrwd_pkg::OE_NONE; // R8 R9
		end
	end

	// Data outputs come straight from the state register; only the pin enable is combinational.
	assign dq_o      = st_r.rdat;
	assign write_o   = (st_r.cyc == ssrwd_pkg::SSRWD_WRITE);
	assign byte_we_o = st_r.mask;
	assign wr_data_o = st_r.wdat;

	// Checks of the decode and pin control.
	logic en_take; // An edge that takes a cycle.
	assign en_take = clk_en_i && take;

	// A low global write makes every lane a write unless the processor strobe overrides it.
	property p_write_global;
		@(posedge clock_i) disable iff (rst_i)
		en_take && !pstart && !global_write_n_i
		|=> write_o && byte_we_o == ssrwd_pkg::MASK_ALL;
	endproperty
	a_write_global: assert property (p_write_global) else $error("Global write not decoded."); // R1

	// Global write high with byte enable high, or with no lane strobed, gives a read.
	property p_read_decode;
		@(posedge clock_i) disable iff (rst_i)
		en_take && global_write_n_i
		&& (byte_write_enable_n_i || lanes_n == ssrwd_pkg::MASK_ALL)
		|=> st_r.cyc == ssrwd_pkg::SSRWD_READ && byte_we_o == ssrwd_pkg::MASK_NONE;
	endproperty
	a_read_decode: assert property (p_read_decode) else $error("Read not decoded."); // R2

	// A byte write takes exactly the lanes whose strobe was low at the taking edge.
	property p_byte_mask;
		@(posedge clock_i) disable iff (rst_i)
		en_take && !pstart && global_write_n_i && !byte_write_enable_n_i
		|=> byte_we_o == ~$past(lanes_n)
		&& write_o == ($past(lanes_n) != ssrwd_pkg::MASK_ALL);
	endproperty
	a_byte_mask: assert property (p_byte_mask) else $error("Byte mask wrong."); // R3

	// The processor strobe while selected always opens a read, whatever the write pins say.
	property p_proc_read;
		@(posedge clock_i) disable iff (rst_i)
		clk_en_i && pstart |=> !write_o && byte_we_o == ssrwd_pkg::MASK_NONE;
	endproperty
	a_proc_read: assert property (p_proc_read) else $error("Processor strobe wrote."); // R4

	// In a read the pin enable follows output enable without waiting for an edge.
	property p_oe_async;
		@(posedge clock_i) disable iff (rst_i)
		st_r.cyc == ssrwd_pkg::SSRWD_READ && $changed(output_enable_n_i)
		|-> dq_oe_o == (output_enable_n_i ? ssrwd_pkg::OE_NONE : ssrwd_pkg::OE_ALL);
	endproperty
	a_oe_async: assert property (p_oe_async) else $error("Enable lags output enable."); // R7

	// A write never drives the pins, so output enable low cannot start a bus fight.
	property p_write_mask;
		@(posedge clock_i) disable iff (rst_i)
		write_o |-> dq_oe_o == ssrwd_pkg::OE_NONE;
	endproperty
	a_write_mask: assert property (p_write_mask) else $error("Pins driven in write."); // R8

	// A strobe while deselected leaves the pins floating and no write running.
	property p_float;
		@(posedge clock_i) disable iff (rst_i)
		clk_en_i && strobe && !chip_select_i |=> dq_oe_o == ssrwd_pkg::OE_NONE && !write_o;
	endproperty
	a_float: assert property (p_float) else $error("Deselected pins driven."); // R9

	// A read with output enable low drives every data bit.
	property p_drive;
		@(posedge clock_i) disable iff (rst_i)
		clk_en_i && pstart ##1 !output_enable_n_i |-> dq_oe_o == ssrwd_pkg::OE_ALL;
	endproperty
	a_drive: assert property (p_drive) else $error("Read pins not driven."); // R10

	// Write data is the word that stood on the pins at the edge that took the write.
	property p_wdata;
		@(posedge clock_i) disable iff (rst_i)
		en_take && !pstart && (!global_write_n_i
		|| (!byte_write_enable_n_i && lanes_n != ssrwd_pkg::MASK_ALL))
		|=> wr_data_o == $past(dq_i);
	endproperty
	a_wdata: assert property (p_wdata) else $error("Write data not captured."); // R1 R3

	// Write pins with no strobe and nothing running are refused, so the bus stays idle.
	property p_idle_hold;
		@(posedge clock_i) disable iff (rst_i)
		clk_en_i && !strobe && st_r.cyc == ssrwd_pkg::SSRWD_IDLE
		|=> st_r.cyc == ssrwd_pkg::SSRWD_IDLE && !write_o;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Write without a cycle."); // R5

	// The word shown on the pins is the array word of the last enabled edge.
	property p_rdat;
		@(posedge clock_i) disable iff (rst_i)
		clk_en_i |=> dq_o == $past(rd_data_i);
	endproperty
	a_rdat: assert property (p_rdat) else $error("Read word not presented."); // R10

	// Clock enable low holds every registered output where it was.
	property p_freeze;
		@(posedge clock_i) disable iff (rst_i)
		!clk_en_i |=> $stable(write_o) && $stable(byte_we_o)
		&& $stable(wr_data_o) && $stable(dq_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while frozen."); // R1 R3

	// Reset is not gated by the clock enable, so this check has no disable condition.
	property p_reset;
		@(posedge clock_i)
		rst_i |=> !write_o && byte_we_o == ssrwd_pkg::MASK_NONE
		&& wr_data_o == ssrwd_pkg::DATA_RST && dq_o == ssrwd_pkg::DATA_RST
		&& dq_oe_o == ssrwd_pkg::OE_NONE;
	endproperty
	a_reset: assert property (p_reset) else $error("Reset left state behind."); // R9

	// Main scenarios that the bench is expected to reach.
	// A processor start followed by output enable low on the next edge.
	c_proc_read: cover property (@(posedge clock_i) disable iff (rst_i)
		clk_en_i && pstart ##1 dq_oe_o == ssrwd_pkg::OE_ALL);
	// A byte write of two lanes that are not neighbours.
	c_byte_write: cover property (@(posedge clock_i) disable iff (rst_i)
		write_o && byte_we_o == 4'h5);
	// A write taken at an edge where no write was running.
	c_read_then_write: cover property (@(posedge clock_i) disable iff (rst_i)
		!write_o && take ##1 write_o);
	// A write ended by a deselect.
	c_deselect: cover property (@(posedge clock_i) disable iff (rst_i)
		write_o ##1 st_r.cyc == ssrwd_pkg::SSRWD_IDLE);

endmodule

//--- ssrwd_ctrl_model.sv
// Controller-side model that drives strobes, write controls, output enable and write data.
module ssrwd_ctrl_model (
	output logic        sel_o = 1'b0,          // Chip select, high.
	output logic        pstb_n_o = 1'b1,       // Processor address strobe, low.
	output logic        cstb_n_o = 1'b1,       // Controller address strobe, low.
	output logic        glob_n_o = 1'b1,       // Global write, low.
	output logic        byte_n_o = 1'b1,       // Byte write enable, low.
	output logic [3:0]  lane_n_o = 4'hF,       // Lane strobes, low, bit 0 is lane 0.
	output logic        oe_n_o = 1'b1,         // Output enable, low.
	output logic [31:0] dq_o = 32'h00000000    // Write data toward the pins.
);
	timeunit 1ns;
	timeprecision 1ns;

	// Presents one request; the caller enters just after a rising edge.
	task automatic put(input logic pstb, cstb, glob, byt, input logic [3:0] lane,
		input logic sel, input logic [31:0] d, input logic rude);
		logic wr;
		wr = ~glob | (~byt & ~(&lane));
		sel_o = sel;
		pstb_n_o = pstb;
		cstb_n_o = cstb;
		// A real controller never pairs a write with a processor start; rude breaks that.
		glob_n_o = glob | (~pstb & ~rude);
		byte_n_o = byt | (~pstb & ~rude);
		lane_n_o = lane;
		// Pins are floated ahead of the edge that starts a write.
		if (wr)
			oe_n_o = 1'b1;
		// Released data lines show the inverse of their last value, never a stale copy.
		dq_o = wr ? d : ~dq_o;
	endtask

	// Moves output enable at any time; it is not tied to the clock.
	task automatic oe(input logic v);
		oe_n_o = v;
	endtask
endmodule

//--- ssrwd_pkg.sv
// Constants, types and the summary of behaviour for the write decode and output enable block.
// What this block does
// R1: Low global write, or byte enable plus lane, writes.
// R2: Otherwise the cycle is a read.
// R3: Byte write updates only lanes strobed low.
// R4: Processor strobe with chip select high always starts a read cycle.
// R5: Controller writes only after processor start or controller strobe.
// R6: Controller floats pins with output enable before writes.
// R7: Pins follow current cycle and unclocked output enable.
// R8: Output enable is masked during write cycles.
// R9: Read pins float when disabled or deselected.
// R10: Read with output enable low drives all bits.
package ssrwd_pkg;

	// Number of byte lanes on the data bus.
	localparam int unsigned LANES = 4;

	// Width of one byte lane.
	localparam int unsigned LANE_W = 8;

	// Width of the whole data bus.
	localparam int unsigned DATA_W = LANES * LANE_W;

	// Byte mask with no lane written.
	localparam logic [LANES-1:0] MASK_NONE = 4'h0;

	// Byte mask with every lane written.
	localparam logic [LANES-1:0] MASK_ALL = 4'hF;

	// Data word reset value.
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

	// Pin enable with every bit floating.
	localparam logic [DATA_W-1:0] OE_NONE = 32'h00000000;

	// Pin enable with every bit driven.
	localparam logic [DATA_W-1:0] OE_ALL = 32'hFFFFFFFF;

	// Kind of cycle that the block is running.
	typedef enum logic [1:0] {
		SSRWD_IDLE  = 2'b00,
		SSRWD_READ  = 2'b01,
		SSRWD_WRITE = 2'b10
	} ssrwd_cyc_e;

	// All state of the block.
	typedef struct packed {
		ssrwd_cyc_e       cyc;   // Current cycle kind.
		logic [LANES-1:0] mask;  // Lanes written this cycle.
		logic [DATA_W-1:0] wdat; // Write data taken from the pins.
		logic [DATA_W-1:0] rdat; // Read data presented on the pins.
	} ssrwd_state_s;

	// Reset value of the state.
	localparam ssrwd_state_s STATE_RST = '{
		cyc:  SSRWD_IDLE,
		mask: MASK_NONE,
		wdat: DATA_RST,
		rdat: DATA_RST
	};

endpackage

//--- tb_sync_sram_write_decode.sv
// Self-checking bench for the write decode and output enable block.
module tb_sync_sram_write_decode;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_i = 1'b0;            // Bench clock, 100 ns period.
	logic        rst_i = 1'b1;              // Synchronous reset.
	logic        clk_en = 1'b1;             // Clock enable driven by the bench.
	logic [31:0] rd_word = 32'hA5C30F96;    // Array word offered for reads.
	logic        sel, pstb_n, cstb_n, glob_n, byte_n, oe_n, write;
	logic [3:0]  lane_n, byte_we;
	logic [31:0] dq_in, dq_out, dq_oe, wr_data;
	int          failures = 0;              // Mismatches seen.
	int          check_count = 0;           // Comparisons made.

	always #50 clock_i = ~clock_i;

	ssrwd_ctrl_model u_ctrl (.sel_o(sel), .pstb_n_o(pstb_n), .cstb_n_o(cstb_n),
		.glob_n_o(glob_n), .byte_n_o(byte_n), .lane_n_o(lane_n), .oe_n_o(oe_n), .dq_o(dq_in));

	ssrwd_core u_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en), .chip_select_i(sel),
		.proc_addr_strobe_n_i(pstb_n), .ctrl_addr_strobe_n_i(cstb_n),
		.global_write_n_i(glob_n), .byte_write_enable_n_i(byte_n),
		.lane0_write_n_i(lane_n[0]), .lane1_write_n_i(lane_n[1]), .lane2_write_n_i(lane_n[2]),
		.lane3_write_n_i(lane_n[3]), .output_enable_n_i(oe_n), .dq_i(dq_in), .dq_o(dq_out),
		.dq_oe_o(dq_oe), .rd_data_i(rd_word), .write_o(write), .byte_we_o(byte_we),
		.wr_data_o(wr_data));

	// Compares one value; an unknown never passes.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Lets one edge take the request, then settles just after it.
	task automatic step();
		@(posedge clock_i);
		#1;
	endtask

	// Every lane pattern, the global write and a plain read through the controller strobe.
	task automatic s_decode();
		logic [3:0] exp;
		for (int k = 0; k < 18; k++) begin
			exp = (k < 16) ? ~4'(k) : ((k == 16) ? ssrwd_pkg::MASK_ALL : ssrwd_pkg::MASK_NONE);
			u_ctrl.put(1'b1, 1'b0, k != 16, k == 17, 4'(k), 1'b1, 32'h1F2E3D4C ^ 32'(k), 1'b0);
			step();
			check("write", 32'(write), 32'(exp != 4'h0));
			check("lanes", 32'(byte_we), 32'(exp));
			if (exp != 4'h0)
				check("wdata", wr_data, 32'h1F2E3D4C ^ 32'(k));
		end
	endtask

	// Processor start with write pins low reads; the read runs on, then a write follows it.
	task automatic s_read_write();
		u_ctrl.put(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 32'h00000000, 1'b1);
		step();
		check("start write", 32'(write), 32'h00000000);
		check("start lanes", 32'(byte_we), 32'h00000000);
		// No strobe and read pins: the read continues with output enable held low over an edge.
		u_ctrl.put(1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1, 32'h00000000, 1'b0);
		u_ctrl.oe(1'b0);
		#1;
		check("read oe", dq_oe, ssrwd_pkg::OE_ALL);
		check("read data", dq_out, rd_word);
		step();
		check("read held", dq_oe, ssrwd_pkg::OE_ALL);
		u_ctrl.oe(1'b1);
		#1;
		check("read off", dq_oe, ssrwd_pkg::OE_NONE);
		step();
		u_ctrl.put(1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, 32'hC0DE1234, 1'b0);
		step();
		check("next write", 32'(write), 32'h00000001);
		check("next data", wr_data, 32'hC0DE1234);
		u_ctrl.oe(1'b0);
		#1;
		check("write mask", dq_oe, ssrwd_pkg::OE_NONE);
		step();
		check("write held", dq_oe, ssrwd_pkg::OE_NONE);
	endtask

	// A deselected start floats a driven read; write pins with nothing running are ignored.
	task automatic s_deselect();
		u_ctrl.put(1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 32'h00000000, 1'b0);
		u_ctrl.oe(1'b0);
		step();
		check("select read", dq_oe, ssrwd_pkg::OE_ALL);
		u_ctrl.put(1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 1'b0, 32'h00000000, 1'b0);
		step();
		check("deselect", dq_oe, ssrwd_pkg::OE_NONE);
		check("deselect write", 32'(write), 32'h00000000);
		u_ctrl.put(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 32'h0BADCAFE, 1'b0);
		step();
		check("idle write", 32'(write), 32'h00000000);
		check("idle lanes", 32'(byte_we), 32'h00000000);
	endtask

	// Clock enable low freezes the state; reset acts even then, and the next edge works.
	task automatic s_freeze_reset();
		u_ctrl.put(1'b1, 1'b0, 1'b1, 1'b0, 4'hC, 1'b1, 32'h5A5A0F0F, 1'b0);
		step();
		check("pre lanes", 32'(byte_we), 32'h00000003);
		clk_en = 1'b0;
		u_ctrl.put(1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1, 32'h00000000, 1'b0);
		repeat (2) step();
		check("frozen write", 32'(write), 32'h00000001);
		check("frozen lanes", 32'(byte_we), 32'h00000003);
		check("frozen data", wr_data, 32'h5A5A0F0F);
		rst_i = 1'b1;
		repeat (2) step();
		check("reset write", 32'(write), 32'h00000000);
		check("reset data", wr_data, 32'h00000000);
		check("reset pins", dq_out, 32'h00000000);
		check("reset oe", dq_oe, ssrwd_pkg::OE_NONE);
		rst_i = 1'b0;
		clk_en = 1'b1;
		u_ctrl.put(1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 1'b1, 32'h13579BDF, 1'b0);
		step();
		check("restart write", 32'(write), 32'h00000001);
		check("restart lanes", 32'(byte_we), 32'h0000000F);
		check("restart data", wr_data, 32'h13579BDF);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Guard against a hang; running out counts as a mismatch.
	initial begin
		#2000000;
		failures++;
		conclude();
	end

	// Main sequence: two reset cycles, then the scenarios.
	initial begin
		repeat (2) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		check("reset lanes", 32'(byte_we), 32'h00000000);
		s_decode();
		s_read_write();
		s_deselect();
		s_freeze_reset();
		conclude();
	end
endmodule
